// [rtl/ecl_pkg.sv]
// shared constants, codes and types of the event counter and logic block unit
package ecl_pkg;
	localparam int CNT_W = 32;
	localparam int NCNT = 2;
	localparam int NLB = 2;
	localparam int NSRC = 20;
	localparam int NTIN = 3;
	// source codes, shared by every cause and table input selection
	localparam logic [4:0] SRC_OFF = 5'h00;
	localparam logic [4:0] SRC_LINE0 = 5'h01;
	localparam logic [4:0] SRC_USER0 = 5'h05;
	localparam logic [4:0] SRC_BEGIN0 = 5'h09;
	localparam logic [4:0] SRC_FINISH0 = 5'h0b;
	localparam logic [4:0] SRC_LB0 = 5'h0d;
	localparam logic [4:0] SRC_EXP_START = 5'h0f;
	localparam logic [4:0] SRC_EXP_END = 5'h10;
	localparam logic [4:0] SRC_FRAME_WAIT = 5'h11;
	localparam logic [4:0] SRC_ACQ = 5'h12;
	localparam logic [4:0] SRC_TICK = 5'h13;
	// qualifier codes
	localparam logic [2:0] Q_LOW = 3'h0;
	localparam logic [2:0] Q_HIGH = 3'h1;
	localparam logic [2:0] Q_FALL = 3'h2;
	localparam logic [2:0] Q_RISE = 3'h3;
	localparam logic [2:0] Q_ANY = 3'h4;
	// field positions inside a cause register
	localparam int SEL_LSB = 0;
	localparam int QUAL_LSB = 8;
	// byte offsets
	localparam logic [7:0] OFS_UNIT_PICK = 8'h00;
	localparam logic [7:0] OFS_INC_CAUSE = 8'h04;
	localparam logic [7:0] OFS_START_CAUSE = 8'h08;
	localparam logic [7:0] OFS_CLEAR_CAUSE = 8'h0c;
	localparam logic [7:0] OFS_BEGIN_DELAY = 8'h10;
	localparam logic [7:0] OFS_FINISH_LIMIT = 8'h14;
	localparam logic [7:0] OFS_PRESENT_TALLY = 8'h18;
	localparam logic [7:0] OFS_CAPTURED = 8'h1c;
	localparam logic [7:0] OFS_TALLY_STATE = 8'h20;
	localparam logic [7:0] OFS_BLOCK_PICK = 8'h24;
	localparam logic [7:0] OFS_TABLE_PICK = 8'h28;
	localparam logic [7:0] OFS_INPUT_PICK = 8'h2c;
	localparam logic [7:0] OFS_INPUT_CAUSE = 8'h30;
	localparam logic [7:0] OFS_TRUTH_WORD = 8'h34;
	localparam logic [7:0] OFS_ROW_POINTER = 8'h38;
	localparam logic [7:0] OFS_ROW_BIT = 8'h3c;
	localparam logic [7:0] OFS_BLOCK_OUT = 8'h40;
	// values after reset
	localparam logic [7:0] TT_RST = 8'h00;
	localparam logic [CNT_W-1:0] TALLY_RST = 32'h0000_0000;
	// tick rate
	localparam longint CLK_HZ = 200000000;
	localparam longint TICK_HZ = 1000000;
	localparam int TICK_CYC = int'(CLK_HZ / TICK_HZ);
	typedef enum logic [2:0]
	{
		state_idle,
		state_awaiting_start,
		state_running,
		state_done,
		state_wrapped
	} ecl_state_t;
	typedef struct packed
	{
		logic [4:0] inc_sel;
		logic [2:0] inc_q;
		logic [4:0] start_sel;
		logic [2:0] start_q;
		logic [4:0] clr_sel;
		logic [2:0] clr_q;
		logic [CNT_W-1:0] delay;
		logic [CNT_W-1:0] limit;
	} ecl_cnt_cfg_t;
	typedef struct packed
	{
		logic [NTIN-1:0][4:0] org;
		logic [NTIN-1:0][2:0] qual;
		logic [7:0] vtt;
		logic [7:0] ett;
	} ecl_lb_cfg_t;
endpackage

// [rtl/ecl_top.sv]
// two event counters and two table logic blocks behind an avalon-mm slave
// Contract
// - finish event after limit qualified increments
// - begin event after delay qualified increments
// - clear captures the tally for software
// - start cause selectable from shared source list
// - start cause level or edge qualified
// - clear cause selectable from same list
// - clear cause level or edge qualified
// - five read-only counter states reported
// - two tables drive one output flip-flop
// - value table data, enable table enable
// - three inputs, eight bit truth table
// - both tables share input selections
// - inputs chosen and qualified per input
// - rows written singly or as word
// - row index input2 msb, bit r
// - output holds unless enable table true
// - enable all ones makes output follow
// - two counters, picked by unit select
// - tally advances on qualified increment cause
// - start and clear causes mutually exclusive
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module ecl_top
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// avalon-mm slave
	input wire logic [7:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	// camera signals
	input wire logic [3:0] LINE_I,
	input wire logic [3:0] USER_OUT_I,
	input wire logic EXPO_START_I,
	input wire logic EXPO_END_I,
	input wire logic FRAME_WAIT_I,
	input wire logic ACQ_ACTIVE_I,
	// produced signals
	output logic [1:0] BEGIN_EVT_O,
	output logic [1:0] FINISH_EVT_O,
	output logic [1:0] LB_OUT_O
);
	localparam int TK_W = $clog2(ecl_pkg::TICK_CYC);
	localparam logic [TK_W-1:0] TK_LAST = TK_W'(ecl_pkg::TICK_CYC - 1);
	localparam logic [ecl_pkg::CNT_W-1:0] TALLY_MAX = '1;

	logic [3:0] line_m_r;
	logic [3:0] line_s_r;
	logic [TK_W-1:0] tick_cnt_r;
	logic tick_r;
	logic [ecl_pkg::NSRC-1:0] sig;
	logic [ecl_pkg::NSRC-1:0] sig_prev_r;
	logic ack_r;
	logic [31:0] readdata_r;
	logic [31:0] rd_mux;
	logic [31:0] wmask;
	logic [31:0] wv;
	logic wr_fire;
	logic unit_r;
	logic block_r;
	logic table_r;
	logic [1:0] in_pick_r;
	logic [2:0] row_ptr_r;
	ecl_pkg::ecl_cnt_cfg_t cnt_cfg_r [ecl_pkg::NCNT];
	ecl_pkg::ecl_state_t st_r [ecl_pkg::NCNT];
	logic [ecl_pkg::CNT_W-1:0] tally_r [ecl_pkg::NCNT];
	logic [ecl_pkg::CNT_W-1:0] cap_r [ecl_pkg::NCNT];
	logic [1:0] beg_r;
	logic [1:0] fin_r;
	ecl_pkg::ecl_lb_cfg_t lb_cfg_r [ecl_pkg::NLB];
	logic [1:0] lb_out_r;

	// off and out-of-range codes never qualify, whatever the qualifier
	function automatic logic qual_f(input logic [ecl_pkg::NSRC-1:0] cur,
		input logic [ecl_pkg::NSRC-1:0] prv, input logic [4:0] sel,
		input logic [2:0] q);
		logic c;
		logic p;
		c = 1'b0;
		p = 1'b0;
		qual_f = 1'b0;
		if (sel != ecl_pkg::SRC_OFF && int'(sel) < ecl_pkg::NSRC)
		begin
			c = cur[sel];
			p = prv[sel];
			case (q)
				ecl_pkg::Q_LOW: qual_f = ~c;
				ecl_pkg::Q_HIGH: qual_f = c;
				ecl_pkg::Q_FALL: qual_f = p & ~c;
				ecl_pkg::Q_RISE: qual_f = ~p & c;
				ecl_pkg::Q_ANY: qual_f = p ^ c;
				default: qual_f = 1'b0;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// inputs, tick and source vector

	// lines come from pins; the first stage is read by the second only
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			line_m_r <= 4'h0;
			line_s_r <= 4'h0;
		end
		else
		begin
			line_m_r <= LINE_I;
			line_s_r <= line_m_r;
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			tick_cnt_r <= '0;
			tick_r <= 1'b0;
		end
		else
		begin
			tick_r <= (tick_cnt_r == TK_LAST);
			tick_cnt_r <= (tick_cnt_r == TK_LAST) ? '0 : tick_cnt_r + 1'b1;
		end
	end

	// counter events feed back only through flip-flops, so no loop forms
	assign sig = {tick_r, ACQ_ACTIVE_I, FRAME_WAIT_I, EXPO_END_I,
		EXPO_START_I, lb_out_r, fin_r, beg_r, USER_OUT_I, line_s_r, 1'b0};

	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			sig_prev_r <= '0;
		else
			sig_prev_r <= sig;
	end

	////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle, then the request is taken

	assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_r;
	assign AVS_READDATA_O = readdata_r;
	assign wr_fire = AVS_WRITE_I & ack_r;

	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			ack_r <= 1'b0;
		else
			ack_r <= (AVS_READ_I | AVS_WRITE_I) & ~ack_r;
	end

	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			readdata_r <= 32'h0000_0000;
		else if (AVS_READ_I & ~ack_r)
			readdata_r <= rd_mux;
	end

	// byte lanes merge into the addressed register's present contents
	always_comb
	begin
		for (int b = 0; b < 4; b++)
			wmask[b*8 +: 8] = {8{AVS_BYTEENABLE_I[b]}};
		wv = (rd_mux & ~wmask) | (AVS_WRITEDATA_I & wmask);
	end

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (AVS_ADDRESS_I == ecl_pkg::OFS_UNIT_PICK)
			rd_mux = {31'h0, unit_r};
		else if (AVS_ADDRESS_I == ecl_pkg::OFS_INC_CAUSE)
			rd_mux = {21'h0, cnt_cfg_r[unit_r].inc_q, 3'h0,
				cnt_cfg_r[unit_r].inc_sel};
		else if (AVS_ADDRESS_I == ecl_pkg::OFS_START_CAUSE)
			rd_mux = {21'h0, cnt_cfg_r[unit_r].start_q, 3'h0,
				cnt_cfg_r[unit_r].start_sel};
		else if (AVS_ADDRESS_I == ecl_pkg::OFS_CLEAR_CAUSE)
			rd_mux = {21'h0, cnt_cfg_r[unit_r].clr_q, 3'h0,
				cnt_cfg_r[unit_r].clr_sel};
		else if (AVS_ADDRESS_I == ecl_pkg::OFS_BEGIN_DELAY)
			rd_mux = cnt_cfg_r[unit_r].delay;
		else if (AVS_ADDRESS_I == ecl_pkg::OFS_FINISH_LIMIT)
			rd_mux = cnt_cfg_r[unit_r].limit;
		else if (AVS_ADDRESS_I == ecl_pkg::OFS_PRESENT_TALLY)
			rd_mux = tally_r[unit_r];
		else if (AVS_ADDRESS_I == ecl_pkg::OFS_CAPTURED)
			rd_mux = cap_r[unit_r];
		else if (AVS_ADDRESS_I == ecl_pkg::OFS_TALLY_STATE)
			rd_mux = {29'h0, st_r[unit_r]};
		else if (AVS_ADDRESS_I == ecl_pkg::OFS_BLOCK_PICK)
			rd_mux = {31'h0, block_r};
		else if (AVS_ADDRESS_I == ecl_pkg::OFS_TABLE_PICK)
			rd_mux = {31'h0, table_r};
		else if (AVS_ADDRESS_I == ecl_pkg::OFS_INPUT_PICK)
			rd_mux = {30'h0, in_pick_r};
		else if (AVS_ADDRESS_I == ecl_pkg::OFS_INPUT_CAUSE)
		begin
			if (in_pick_r < 2'(ecl_pkg::NTIN))
				rd_mux = {21'h0, lb_cfg_r[block_r].qual[in_pick_r], 3'h0,
					lb_cfg_r[block_r].org[in_pick_r]};
		end
		else if (AVS_ADDRESS_I == ecl_pkg::OFS_TRUTH_WORD)
			rd_mux = {24'h0, table_r ? lb_cfg_r[block_r].ett :
				lb_cfg_r[block_r].vtt};
		else if (AVS_ADDRESS_I == ecl_pkg::OFS_ROW_POINTER)
			rd_mux = {29'h0, row_ptr_r};
		else if (AVS_ADDRESS_I == ecl_pkg::OFS_ROW_BIT)
			rd_mux = {31'h0, table_r ? lb_cfg_r[block_r].ett[row_ptr_r] :
				lb_cfg_r[block_r].vtt[row_ptr_r]};
		else if (AVS_ADDRESS_I == ecl_pkg::OFS_BLOCK_OUT)
			rd_mux = {30'h0, lb_out_r};
	end

	// selection registers
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			unit_r <= 1'b0;
			block_r <= 1'b0;
			table_r <= 1'b0;
			in_pick_r <= 2'h0;
			row_ptr_r <= 3'h0;
		end
		else if (wr_fire)
		begin
			if (AVS_ADDRESS_I == ecl_pkg::OFS_UNIT_PICK)
				unit_r <= wv[0];
			else if (AVS_ADDRESS_I == ecl_pkg::OFS_BLOCK_PICK)
				block_r <= wv[0];
			else if (AVS_ADDRESS_I == ecl_pkg::OFS_TABLE_PICK)
				table_r <= wv[0];
			else if (AVS_ADDRESS_I == ecl_pkg::OFS_INPUT_PICK)
				in_pick_r <= wv[1:0];
			else if (AVS_ADDRESS_I == ecl_pkg::OFS_ROW_POINTER)
				row_ptr_r <= wv[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// event counters

	assign BEGIN_EVT_O = beg_r;
	assign FINISH_EVT_O = fin_r;

	for (genvar i = 0; i < ecl_pkg::NCNT; i++)
	begin : g_cnt
		logic picked;
		logic cfg_wr;
		logic inc;
		logic start;
		logic clr;
		logic has_start;
		logic [ecl_pkg::CNT_W-1:0] nxt;
		assign picked = wr_fire & (unit_r == 1'(i));
		assign cfg_wr = picked & (AVS_ADDRESS_I >= ecl_pkg::OFS_INC_CAUSE) &
			(AVS_ADDRESS_I <= ecl_pkg::OFS_FINISH_LIMIT);
		assign inc = qual_f(sig, sig_prev_r, cnt_cfg_r[i].inc_sel,
			cnt_cfg_r[i].inc_q);
		assign start = qual_f(sig, sig_prev_r, cnt_cfg_r[i].start_sel,
			cnt_cfg_r[i].start_q);
		assign clr = qual_f(sig, sig_prev_r, cnt_cfg_r[i].clr_sel,
			cnt_cfg_r[i].clr_q);
		assign has_start = (cnt_cfg_r[i].start_sel != ecl_pkg::SRC_OFF);
		assign nxt = tally_r[i] + 1'b1;

		always_ff @(posedge CLK_I)
		begin
			if (RST_I)
				cnt_cfg_r[i] <= '0;
			else if (picked)
			begin
				if (AVS_ADDRESS_I == ecl_pkg::OFS_INC_CAUSE)
				begin
					cnt_cfg_r[i].inc_sel <= wv[ecl_pkg::SEL_LSB +: 5];
					cnt_cfg_r[i].inc_q <= wv[ecl_pkg::QUAL_LSB +: 3];
				end
				else if (AVS_ADDRESS_I == ecl_pkg::OFS_START_CAUSE)
				begin
					cnt_cfg_r[i].start_sel <= wv[ecl_pkg::SEL_LSB +: 5];
					cnt_cfg_r[i].start_q <= wv[ecl_pkg::QUAL_LSB +: 3];
					if (wv[ecl_pkg::SEL_LSB +: 5] != ecl_pkg::SRC_OFF)
						cnt_cfg_r[i].clr_sel <= ecl_pkg::SRC_OFF;
				end
				else if (AVS_ADDRESS_I == ecl_pkg::OFS_CLEAR_CAUSE)
				begin
					cnt_cfg_r[i].clr_sel <= wv[ecl_pkg::SEL_LSB +: 5];
					cnt_cfg_r[i].clr_q <= wv[ecl_pkg::QUAL_LSB +: 3];
					if (wv[ecl_pkg::SEL_LSB +: 5] != ecl_pkg::SRC_OFF)
						cnt_cfg_r[i].start_sel <= ecl_pkg::SRC_OFF;
				end
				else if (AVS_ADDRESS_I == ecl_pkg::OFS_BEGIN_DELAY)
					cnt_cfg_r[i].delay <= wv;
				else if (AVS_ADDRESS_I == ecl_pkg::OFS_FINISH_LIMIT)
					cnt_cfg_r[i].limit <= wv;
			end
		end

		// a config write restarts the counter from idle with tally zero
		always_ff @(posedge CLK_I)
		begin
			if (RST_I)
			begin
				st_r[i] <= ecl_pkg::state_idle;
				tally_r[i] <= ecl_pkg::TALLY_RST;
				cap_r[i] <= ecl_pkg::TALLY_RST;
				beg_r[i] <= 1'b0;
				fin_r[i] <= 1'b0;
			end
			else
			begin
				beg_r[i] <= 1'b0;
				fin_r[i] <= 1'b0;
				if (picked && AVS_ADDRESS_I == ecl_pkg::OFS_CAPTURED)
					cap_r[i] <= wv;
				if (cfg_wr)
				begin
					st_r[i] <= ecl_pkg::state_idle;
					tally_r[i] <= ecl_pkg::TALLY_RST;
				end
				else if (clr)
				begin
					// capture wins over a software write in the same cycle
					cap_r[i] <= tally_r[i];
					tally_r[i] <= ecl_pkg::TALLY_RST;
					st_r[i] <= has_start ? ecl_pkg::state_awaiting_start :
						ecl_pkg::state_running;
				end
				else
				begin
					case (st_r[i])
						ecl_pkg::state_idle:
						begin
							st_r[i] <= has_start ? ecl_pkg::state_awaiting_start
								: ecl_pkg::state_running;
							beg_r[i] <= ~has_start &
								(cnt_cfg_r[i].delay == '0);
						end
						ecl_pkg::state_running:
						begin
							if (inc && tally_r[i] == TALLY_MAX)
								st_r[i] <= ecl_pkg::state_wrapped;
							else if (inc)
							begin
								tally_r[i] <= nxt;
								beg_r[i] <= (nxt == cnt_cfg_r[i].delay);
								if (nxt == cnt_cfg_r[i].limit)
								begin
									fin_r[i] <= 1'b1;
									st_r[i] <= ecl_pkg::state_done;
								end
							end
						end
						default:
						begin
							// awaiting, done and wrapped all rearm on start
							if (has_start && start)
							begin
								st_r[i] <= ecl_pkg::state_running;
								tally_r[i] <= ecl_pkg::TALLY_RST;
								beg_r[i] <= (cnt_cfg_r[i].delay == '0);
							end
						end
					endcase
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// logic blocks

	assign LB_OUT_O = lb_out_r;

	for (genvar k = 0; k < ecl_pkg::NLB; k++)
	begin : g_lb
		logic picked;
		logic [2:0] row;
		assign picked = wr_fire & (block_r == 1'(k));
		for (genvar n = 0; n < ecl_pkg::NTIN; n++)
		begin : g_in
			assign row[n] = qual_f(sig, sig_prev_r, lb_cfg_r[k].org[n],
				lb_cfg_r[k].qual[n]);
		end

		always_ff @(posedge CLK_I)
		begin
			if (RST_I)
			begin
				lb_cfg_r[k].org <= '0;
				lb_cfg_r[k].qual <= '0;
				lb_cfg_r[k].vtt <= ecl_pkg::TT_RST;
				lb_cfg_r[k].ett <= ecl_pkg::TT_RST;
			end
			else if (picked)
			begin
				// one input set serves both tables
				if (AVS_ADDRESS_I == ecl_pkg::OFS_INPUT_CAUSE &&
					in_pick_r < 2'(ecl_pkg::NTIN))
				begin
					lb_cfg_r[k].org[in_pick_r] <=
						wv[ecl_pkg::SEL_LSB +: 5];
					lb_cfg_r[k].qual[in_pick_r] <=
						wv[ecl_pkg::QUAL_LSB +: 3];
				end
				else if (AVS_ADDRESS_I == ecl_pkg::OFS_TRUTH_WORD)
				begin
					if (table_r)
						lb_cfg_r[k].ett <= wv[7:0];
					else
						lb_cfg_r[k].vtt <= wv[7:0];
				end
				else if (AVS_ADDRESS_I == ecl_pkg::OFS_ROW_BIT)
				begin
					if (table_r)
						lb_cfg_r[k].ett[row_ptr_r] <= wv[0];
					else
						lb_cfg_r[k].vtt[row_ptr_r] <= wv[0];
				end
			end
		end

		// enable table all ones turns the latch into a one-clock follower
		always_ff @(posedge CLK_I)
		begin
			if (RST_I)
				lb_out_r[k] <= 1'b0;
			else if (lb_cfg_r[k].ett[row])
				lb_out_r[k] <= lb_cfg_r[k].vtt[row];
		end
	end
endmodule

// [verif/ecl_top_properties.sv]
// concurrent checks on the ports of the event counter and logic block unit
`timescale 1ns/1ps
module ecl_top_properties
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// avalon-mm slave
	input wire logic [7:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_READDATA_O,
	input wire logic AVS_WAITREQUEST_O,
	// produced signals
	input wire logic [1:0] BEGIN_EVT_O,
	input wire logic [1:0] FINISH_EVT_O,
	input wire logic [1:0] LB_OUT_O
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (RST_I);
	////////////////////////////////////////////////////////////////
	logic req;
	assign req = AVS_READ_I | AVS_WRITE_I;
	a_wait_first: assert property (req && !$past(req) |-> AVS_WAITREQUEST_O)
		else $error("no wait cycle on new request");
	a_wait_one: assert property (req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
		else $error("wait longer than one cycle");
	a_wait_idle: assert property (!req |-> !AVS_WAITREQUEST_O)
		else $error("wait without request");
	// a finished unit sits in done, so two finish pulses cannot touch
	a_finish_single: assert property (FINISH_EVT_O[0] |=> !FINISH_EVT_O[0])
		else $error("finish pulse longer than one cycle");
	// checked through reset, so the default disable is overridden
	a_reset_quiet: assert property (disable iff (1'b0) RST_I |=>
		BEGIN_EVT_O == 2'h0 && FINISH_EVT_O == 2'h0 && LB_OUT_O == 2'h0)
		else $error("outputs active after reset");
	a_rdata_hold: assert property (!AVS_READ_I ##1 !AVS_READ_I
		|-> $stable(AVS_READDATA_O))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (AVS_READ_I && !AVS_WAITREQUEST_O
		&& AVS_ADDRESS_I > 8'h40 |-> AVS_READDATA_O == 32'h0)
		else $error("unmapped read not zero");
	a_state_range: assert property (AVS_READ_I && !AVS_WAITREQUEST_O
		&& AVS_ADDRESS_I == ecl_pkg::OFS_TALLY_STATE
		|-> AVS_READDATA_O <= 32'h4)
		else $error("state code out of range");
	c_finish: cover property (FINISH_EVT_O[0]);
endmodule

// [verif/ecl_cam_model.sv]
// camera side source of lines, user outputs and exposure levels
`timescale 1ns/1ps
module ecl_cam_model
(
	// clock
	input wire logic clk_i,
	// levels wanted by the bench
	input wire logic [11:0] want_i,
	// camera signals
	output logic [3:0] line_o,
	output logic [3:0] user_o,
	output logic [3:0] misc_o
);
	// same-clock logic: levels move only just after an edge
	always @(posedge clk_i)
		{misc_o, user_o, line_o} <= want_i;
endmodule

// [verif/ecl_top_tb_top.sv]
// register level bench of the event counter and logic block unit
`timescale 1ns/1ps
module ecl_top_tb_top;
	logic CLK_I, RST_I, AVS_READ_I, AVS_WRITE_I, AVS_WAITREQUEST_O;
	logic [7:0] AVS_ADDRESS_I;
	logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O;
	logic [1:0] BEGIN_EVT_O, FINISH_EVT_O, LB_OUT_O;
	logic [3:0] line_w, user_w, misc_w;
	logic [11:0] want;
	logic [7:0] vtt;
	int miscompares, n_checks, nbeg, nfin, nfin1;
	////////////////////////////////////////////////////////////////
	ecl_cam_model ecl_cam_model_inst (.clk_i(CLK_I), .want_i(want),
		.line_o(line_w), .user_o(user_w), .misc_o(misc_w));
	ecl_top ecl_top_inst (.CLK_I(CLK_I), .RST_I(RST_I),
		.AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
		.AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
		.AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(AVS_READDATA_O),
		.AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .LINE_I(line_w),
		.USER_OUT_I(user_w), .EXPO_START_I(misc_w[0]),
		.EXPO_END_I(misc_w[1]), .FRAME_WAIT_I(misc_w[2]),
		.ACQ_ACTIVE_I(misc_w[3]), .BEGIN_EVT_O(BEGIN_EVT_O),
		.FINISH_EVT_O(FINISH_EVT_O), .LB_OUT_O(LB_OUT_O));
	always #2.5 CLK_I = ~CLK_I;
	always @(posedge CLK_I)
	begin
		if (BEGIN_EVT_O[0] === 1'b1)
			nbeg++;
		if (FINISH_EVT_O[0] === 1'b1)
			nfin++;
		if (FINISH_EVT_O[1] === 1'b1)
			nfin1++;
	end
	////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (miscompares == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK_I);
	endtask
	// request held until the edge that sees waitrequest low
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge CLK_I);
		AVS_ADDRESS_I <= a;
		AVS_WRITEDATA_I <= d;
		AVS_WRITE_I <= w;
		AVS_READ_I <= !w;
		n = 0;
		do
		begin
			@(posedge CLK_I);
			n++;
		end
		while (AVS_WAITREQUEST_O !== 1'b0 && n < 20);
		q = AVS_READDATA_O;
		AVS_READ_I <= 1'b0;
		AVS_WRITE_I <= 1'b0;
		if (n >= 20)
		begin
			miscompares++;
			stop_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		acc(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		acc(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	// one high phase on a user output, long enough for sync and edge logic
	task automatic pulse(input int b);
		@(posedge CLK_I);
		want[4+b] <= 1'b1;
		cyc(4);
		want[4+b] <= 1'b0;
		cyc(4);
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		CLK_I = 1'b0;
		RST_I = 1'b1;
		AVS_READ_I = 1'b0;
		AVS_WRITE_I = 1'b0;
		AVS_ADDRESS_I = 8'h00;
		AVS_WRITEDATA_I = 32'h0;
		want = 12'h000;
		vtt = 8'hc0;
		cyc(5);
		RST_I <= 1'b0;
		cyc(2);
		rd(ecl_pkg::OFS_TALLY_STATE, 32'h2);
		rd(ecl_pkg::OFS_TRUTH_WORD, 32'h0);
		wr(ecl_pkg::OFS_UNIT_PICK, 32'h0);
		wr(ecl_pkg::OFS_BEGIN_DELAY, 32'h1);
		wr(ecl_pkg::OFS_FINISH_LIMIT, 32'h2);
		wr(ecl_pkg::OFS_INC_CAUSE, 32'h305);
		cyc(2);
		nbeg = 0;
		nfin = 0;
		pulse(0);
		rd(ecl_pkg::OFS_PRESENT_TALLY, 32'h1);
		chk(nbeg, 1);
		chk(nfin, 0);
		pulse(0);
		chk(nfin, 1);
		rd(ecl_pkg::OFS_PRESENT_TALLY, 32'h2);
		rd(ecl_pkg::OFS_TALLY_STATE, 32'h3);
		wr(ecl_pkg::OFS_START_CAUSE, 32'h107);
		cyc(2);
		rd(ecl_pkg::OFS_TALLY_STATE, 32'h1);
		pulse(2);
		rd(ecl_pkg::OFS_TALLY_STATE, 32'h2);
		wr(ecl_pkg::OFS_CLEAR_CAUSE, 32'h306);
		rd(ecl_pkg::OFS_START_CAUSE, 32'h100);
		cyc(2);
		pulse(0);
		pulse(1);
		rd(ecl_pkg::OFS_CAPTURED, 32'h1);
		rd(ecl_pkg::OFS_PRESENT_TALLY, 32'h0);
		wr(ecl_pkg::OFS_UNIT_PICK, 32'h1);
		rd(ecl_pkg::OFS_CAPTURED, 32'h0);
		// logic block 0: and of inputs 1 and 2, enable all ones
		wr(ecl_pkg::OFS_BLOCK_PICK, 32'h0);
		wr(ecl_pkg::OFS_TABLE_PICK, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			wr(ecl_pkg::OFS_INPUT_PICK, i);
			wr(ecl_pkg::OFS_INPUT_CAUSE, 32'h105 + i);
		end
		wr(ecl_pkg::OFS_TRUTH_WORD, {24'h0, vtt});
		wr(ecl_pkg::OFS_TABLE_PICK, 32'h1);
		wr(ecl_pkg::OFS_TRUTH_WORD, 32'hff);
		wr(ecl_pkg::OFS_INPUT_PICK, 32'h1);
		rd(ecl_pkg::OFS_INPUT_CAUSE, 32'h106);
		for (int v = 0; v < 8; v++)
		begin
			@(posedge CLK_I);
			want[6:4] <= v[2:0];
			cyc(4);
			chk({31'h0, LB_OUT_O[0]}, {31'h0, vtt[v]});
		end
		wr(ecl_pkg::OFS_TABLE_PICK, 32'h0);
		wr(ecl_pkg::OFS_ROW_POINTER, 32'h7);
		wr(ecl_pkg::OFS_ROW_BIT, 32'h0);
		cyc(2);
		chk({31'h0, LB_OUT_O[0]}, 32'h0);
		rd(ecl_pkg::OFS_TRUTH_WORD, 32'h40);
		// enable table cleared: value change must not reach the output
		wr(ecl_pkg::OFS_TABLE_PICK, 32'h1);
		wr(ecl_pkg::OFS_TRUTH_WORD, 32'h0);
		wr(ecl_pkg::OFS_TABLE_PICK, 32'h0);
		wr(ecl_pkg::OFS_TRUTH_WORD, 32'hff);
		cyc(3);
		chk({31'h0, LB_OUT_O[0]}, 32'h0);
		rd(ecl_pkg::OFS_BLOCK_OUT, 32'h0);
		wr(ecl_pkg::OFS_TABLE_PICK, 32'h1);
		wr(ecl_pkg::OFS_ROW_POINTER, 32'h7);
		wr(ecl_pkg::OFS_ROW_BIT, 32'h1);
		cyc(2);
		chk({31'h0, LB_OUT_O[0]}, 32'h1);
		// counter 1: falling line edge, then either edge of a user output
		wr(ecl_pkg::OFS_FINISH_LIMIT, 32'h2);
		wr(ecl_pkg::OFS_INC_CAUSE, 32'h201);
		cyc(2);
		@(posedge CLK_I);
		want[0] <= 1'b1;
		cyc(6);
		want[0] <= 1'b0;
		cyc(6);
		rd(ecl_pkg::OFS_PRESENT_TALLY, 32'h1);
		wr(ecl_pkg::OFS_INC_CAUSE, 32'h408);
		cyc(2);
		nfin1 = 0;
		pulse(3);
		chk(nfin1, 1);
		rd(ecl_pkg::OFS_PRESENT_TALLY, 32'h2);
		rd(ecl_pkg::OFS_TALLY_STATE, 32'h3);
		// logic block 1: input 0 is acquisition active, taken when low
		wr(ecl_pkg::OFS_BLOCK_PICK, 32'h1);
		wr(ecl_pkg::OFS_TABLE_PICK, 32'h0);
		wr(ecl_pkg::OFS_INPUT_PICK, 32'h0);
		wr(ecl_pkg::OFS_INPUT_CAUSE, 32'h012);
		wr(ecl_pkg::OFS_TRUTH_WORD, 32'haa);
		wr(ecl_pkg::OFS_TABLE_PICK, 32'h1);
		wr(ecl_pkg::OFS_TRUTH_WORD, 32'hff);
		cyc(2);
		chk({31'h0, LB_OUT_O[1]}, 32'h1);
		@(posedge CLK_I);
		want[11] <= 1'b1;
		cyc(4);
		chk({31'h0, LB_OUT_O[1]}, 32'h0);
		rd(ecl_pkg::OFS_BLOCK_OUT, 32'h1);
		wr(8'hfc, 32'hffff_ffff);
		rd(8'hfc, 32'h0);
		stop_test();
	end
endmodule
bind ecl_top ecl_top_properties ecl_top_properties_inst (.CLK_I(CLK_I),
	.RST_I(RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
	.AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
	.AVS_READDATA_O(AVS_READDATA_O),
	.AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .BEGIN_EVT_O(BEGIN_EVT_O),
	.FINISH_EVT_O(FINISH_EVT_O), .LB_OUT_O(LB_OUT_O));
